// ### rtl/smm_monitor.sv
// Selective message monitor: lookup filter, stacks and register slave
// Contract
// - Monitor-only operation waits for the host's monitor start command.
// - Combined terminal and monitor operation runs without any start command.
// - Lookup address is base 0280 plus terminal address, T/R and subaddress bit 4.
// - Low four subaddress bits pick the enable bit in the lookup word.
// - Even words enable subaddresses 0-15, odd words enable subaddresses 16-31.
// - A cleared lookup bit drops the message and resumes command search; a cleared receive bit first checks for a contiguous transmit command.
// - After dropping, a following status word may be taken as a command.
// - A set lookup bit writes a command stack entry and sequential data words.
// - Receive message: command word in command stack, data then status in data stack.
// - Selected receive command of terminal-to-terminal transfer sets status bit 11.
// - Transmit-only selection stores transmit command, statuses and data, skips receive.
// - Pointers live at 102/106 and 103/107; lookup table spans 0280 to 02FF.
// - Monitor locations and stacks stay apart from terminal locations and stack.
// - Messages on channel A or B pass through the same filter.
// - Block status end-of-message bit 15 is set on every completed message.
// - Block status bit 13 is low for channel A, high for channel B.
// - Data stack size from configuration 3 bits 10:8, pointer wraps in range.
`timescale 1ns/1ns
module smm_monitor #(
	parameter int AXI_AW = 8
) (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0]   awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	input  wire logic [AXI_AW-1:0]   araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	// Decoded bus words, both channels
	input  wire logic                wd_stb,
	input  wire smm_pkg::smm_word_t  wd,
	input  wire logic                msg_end,
	// Terminal function of the same device is active
	input  wire logic                rt_active,
	// Shared RAM port
	output smm_pkg::smm_ram_req_t    ram,
	input  wire logic                ram_ack,
	input  wire logic [15:0]         ram_rdata,
	// State
	output logic                     running
);
	import smm_pkg::*;

	typedef enum logic [3:0] {
		S_SEARCH, S_LUT, S_RXW, S_CP, S_DP, S_COL, S_WD, S_ENTRY, S_WBC, S_WBD
	} smm_state_t;

	smm_state_t   state_reg;
	smm_ram_req_t ram_reg;
	smm_word_t    pw_reg;
	logic         pend_reg;
	logic         end_reg;
	logic         started_reg;
	logic [15:0]  cfg1_reg;
	logic [15:0]  cfg3_reg;
	logic         start_reg;
	logic [15:0]  cmd_reg;
	logic         chb_reg;
	logic         tx2_reg;
	logic         first_reg;
	logic         rtrt_reg;
	logic         fmt_reg;
	logic         roll_reg;
	logic [15:0]  cptr_reg;
	logic [15:0]  dptr_reg;
	logic [15:0]  dstart_reg;
	logic [15:0]  cnt_reg;
	logic [1:0]   idx_reg;
	logic [15:0]  bsw_last_reg;
	logic [15:0]  bsw;
	logic [15:0]  cmask;
	logic [15:0]  dmask;
	logic [15:0]  cp_addr;
	logic [15:0]  dp_addr;
	logic [15:0]  ent_w [0:3];
	logic         enabled;
	logic         ram_fire;
	logic         take;
	logic         rxw_pair;
	logic         sel_bit;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [15:0] lut_addr(input logic [15:0] c);
		return LUT_BASE | {9'h000, c[15:11], c[CMD_TR], c[CMD_SA4]};
	endfunction

	// Advance inside an aligned window; rollover is seen by the caller
	function automatic logic [15:0] ptr_add(input logic [15:0] p,
			input logic [15:0] n, input logic [15:0] m);
		return (p & ~m) | ((p + n) & m);
	endfunction

	function automatic smm_ram_req_t rd_req(input logic [15:0] a);
		return '{valid: 1'b1, we: 1'b0, addr: a, wdata: 16'h0000};
	endfunction

	function automatic smm_ram_req_t wr_req(input logic [15:0] a, input logic [15:0] d);
		return '{valid: 1'b1, we: 1'b1, addr: a, wdata: d};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register slave

	smm_axil #(.AXI_AW(AXI_AW)) u_regs (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.awaddr    (awaddr),
		.awvalid   (awvalid),
		.awready   (awready),
		.wdata     (wdata),
		.wstrb     (wstrb),
		.wvalid    (wvalid),
		.wready    (wready),
		.bresp     (bresp),
		.bvalid    (bvalid),
		.bready    (bready),
		.araddr    (araddr),
		.arvalid   (arvalid),
		.arready   (arready),
		.rdata     (rdata),
		.rresp     (rresp),
		.rvalid    (rvalid),
		.rready    (rready),
		.cfg1_reg  (cfg1_reg),
		.cfg3_reg  (cfg3_reg),
		.start_reg (start_reg),
		.stat_word ({bsw_last_reg, 14'h0000, state_reg != S_SEARCH, running})
	);

	////////////////////////////////////////////////////////////////////////
	// Mode and start control

	assign enabled = cfg3_reg[CFG3_ENH] & ~cfg1_reg[CFG1_ROLE]
		& cfg1_reg[CFG1_MON] & cfg1_reg[CFG1_MSGMON];

	always_ff @(posedge aclk) begin
		if (!aresetn || !enabled)
			started_reg <= 1'b0;
		else if (start_reg)
			started_reg <= 1'b1;
	end

	assign running = enabled & (rt_active | started_reg);

	////////////////////////////////////////////////////////////////////////
	// Word and end-of-message holding

	assign rxw_pair = pw_reg.cmd_sync & ~pw_reg.gap & pw_reg.ok;
	assign take = pend_reg & ((state_reg == S_SEARCH) | (state_reg == S_COL)
		| ((state_reg == S_RXW) & rxw_pair));

	// One slot only; a word that overruns it replaces the held one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_reg <= 1'b0;
			pw_reg   <= '0;
		end else if (wd_stb) begin
			pend_reg <= 1'b1;
			pw_reg   <= wd;
		end else if (take) begin
			pend_reg <= 1'b0;
		end
	end

	// Stale ends outside a message are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn)
			end_reg <= 1'b0;
		else if (msg_end)
			end_reg <= 1'b1;
		else if ((state_reg == S_SEARCH) || (!pend_reg
				&& (state_reg == S_COL || state_reg == S_RXW)))
			end_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Derived values

	assign cmask = 16'((CMD_BASE_WORDS << (2 * int'(cfg3_reg[CFG3_CSZ_LO +: 2]))) - 1);
	assign dmask = 16'((DATA_BASE_WORDS << int'(cfg3_reg[CFG3_DSZ_LO +: 3])) - 1);

	// pointer words clear of terminal area
	assign cp_addr = cfg1_reg[CFG1_AREA_B] ? CPTR_B_ADDR : CPTR_A_ADDR;
	assign dp_addr = cfg1_reg[CFG1_AREA_B] ? DPTR_B_ADDR : DPTR_A_ADDR;

	// enable bit by low subaddress bits
	assign sel_bit = ram_rdata[cmd_reg[8:5]];

	assign ram      = ram_reg;
	assign ram_fire = ram_reg.valid & ram_ack;

	always_comb begin
		bsw = 16'h0000;
		bsw[BSW_EOM]  = 1'b1;
		bsw[BSW_CHB]  = chb_reg;
		bsw[BSW_ERR]  = fmt_reg;
		bsw[BSW_RTRT] = rtrt_reg;
		bsw[BSW_FMT]  = fmt_reg;
		bsw[BSW_GOOD] = ~fmt_reg;
		bsw[BSW_ROLL] = roll_reg;
	end

	// Entry: status, stored word count, data block pointer, command
	assign ent_w[0] = bsw;
	assign ent_w[1] = cnt_reg;
	assign ent_w[2] = dstart_reg;
	assign ent_w[3] = cmd_reg;

	////////////////////////////////////////////////////////////////////////
	// Message engine

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= S_SEARCH;
			ram_reg      <= '0;
			cmd_reg      <= '0;
			chb_reg      <= 1'b0;
			tx2_reg      <= 1'b0;
			first_reg    <= 1'b0;
			rtrt_reg     <= 1'b0;
			fmt_reg      <= 1'b0;
			roll_reg     <= 1'b0;
			cptr_reg     <= '0;
			dptr_reg     <= '0;
			dstart_reg   <= '0;
			cnt_reg      <= '0;
			idx_reg      <= '0;
			bsw_last_reg <= '0;
		end else begin
			if (ram_fire)
				ram_reg.valid <= 1'b0;
			unique case (state_reg)
				S_SEARCH: begin
					if (take && running && pw_reg.cmd_sync && pw_reg.ok) begin
						cmd_reg   <= pw_reg.data;
						chb_reg   <= pw_reg.chan_b;
						tx2_reg   <= 1'b0;
						rtrt_reg  <= 1'b0;
						fmt_reg   <= 1'b0;
						roll_reg  <= 1'b0;
						cnt_reg   <= '0;
						ram_reg   <= rd_req(lut_addr(pw_reg.data));
						state_reg <= S_LUT;
					end
				end
				S_LUT: begin
					if (ram_fire) begin
						if (sel_bit) begin
							first_reg <= tx2_reg;
							ram_reg   <= rd_req(cp_addr);
							state_reg <= S_CP;
						end else if (!cmd_reg[CMD_TR] && !tx2_reg) begin
							state_reg <= S_RXW;
						end else begin
							state_reg <= S_SEARCH;
						end
					end
				end
				S_RXW: begin
					// Disabled receive: a contiguous command may be its transmit half
					if (pend_reg) begin
						if (rxw_pair) begin
							cmd_reg   <= pw_reg.data;
							tx2_reg   <= 1'b1;
							ram_reg   <= rd_req(lut_addr(pw_reg.data));
							state_reg <= S_LUT;
						end else begin
							state_reg <= S_SEARCH;
						end
					end else if (end_reg) begin
						state_reg <= S_SEARCH;
					end
				end
				S_CP: begin
					if (ram_fire) begin
						cptr_reg  <= ram_rdata;
						ram_reg   <= rd_req(dp_addr);
						state_reg <= S_DP;
					end
				end
				S_DP: begin
					if (ram_fire) begin
						dptr_reg   <= ram_rdata;
						dstart_reg <= ram_rdata;
						if (first_reg) begin
							ram_reg   <= wr_req(ram_rdata, cmd_reg);
							state_reg <= S_WD;
						end else begin
							state_reg <= S_COL;
						end
					end
				end
				S_COL: begin
					if (take) begin
						if (cnt_reg == 16'h0000 && !tx2_reg && !cmd_reg[CMD_TR]
								&& pw_reg.cmd_sync && !pw_reg.gap)
							rtrt_reg <= 1'b1;
						if (!pw_reg.ok)
							fmt_reg <= 1'b1;
						ram_reg   <= wr_req(dptr_reg, pw_reg.data);
						state_reg <= S_WD;
					end else if (end_reg) begin
						idx_reg   <= '0;
						ram_reg   <= wr_req(ptr_add(cptr_reg, 16'h0000, cmask), ent_w[0]);
						state_reg <= S_ENTRY;
					end
				end
				S_WD: begin
					if (ram_fire) begin
						dptr_reg  <= ptr_add(dptr_reg, 16'h0001, dmask);
						if (((dptr_reg + 16'h0001) & dmask) == 16'h0000)
							roll_reg <= 1'b1;
						cnt_reg   <= cnt_reg + 16'h0001;
						first_reg <= 1'b0;
						state_reg <= S_COL;
					end
				end
				S_ENTRY: begin
					if (ram_fire) begin
						if (idx_reg == ENTRY_LAST) begin
							ram_reg   <= wr_req(cp_addr, ptr_add(cptr_reg, 16'h0004, cmask));
							state_reg <= S_WBC;
						end else begin
							idx_reg <= idx_reg + 2'd1;
							ram_reg <= wr_req(ptr_add(cptr_reg, {14'h0000, idx_reg + 2'd1},
								cmask), ent_w[idx_reg + 2'd1]);
						end
					end
				end
				S_WBC: begin
					if (ram_fire) begin
						ram_reg   <= wr_req(dp_addr, dptr_reg);
						state_reg <= S_WBD;
					end
				end
				S_WBD: begin
					if (ram_fire) begin
						bsw_last_reg <= bsw;
						state_reg    <= S_SEARCH;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_start_gate: assert property (
		state_reg == S_SEARCH && !rt_active && !started_reg |=> state_reg == S_SEARCH)
		else $error("monitor left search before start command");

	a_combined_run: assert property (
		state_reg == S_SEARCH && enabled && rt_active && pend_reg
		&& pw_reg.cmd_sync && pw_reg.ok |=> state_reg == S_LUT && ram.valid)
		else $error("combined mode did not look up a command");

	a_lut_address: assert property (
		state_reg == S_LUT && ram.valid |-> !ram.we && ram.addr
		== {6'h00, 3'b101, cmd_reg[15:11], cmd_reg[CMD_TR], cmd_reg[CMD_SA4]})
		else $error("lookup address malformed");

	a_drop_disabled: assert property (
		state_reg == S_LUT && ram_fire && !sel_bit && cmd_reg[CMD_TR]
		|=> state_reg == S_SEARCH ##1 !ram.we)
		else $error("disabled message not dropped");

	a_entry_start: assert property (
		state_reg == S_LUT && ram_fire && sel_bit
		|=> state_reg == S_CP && ram.addr == $past(cp_addr))
		else $error("enabled message did not fetch command pointer");

	a_eom_channel: assert property (
		state_reg == S_ENTRY && ram.valid && idx_reg == 2'd0
		|-> ram.wdata[BSW_EOM] && ram.wdata[BSW_CHB] == chb_reg)
		else $error("block status lacks end or channel bit");

	a_ptr_wrap: assert property (
		state_reg == S_WD && ram_fire
		|=> (dptr_reg & ~dmask) == ($past(dptr_reg) & ~dmask))
		else $error("data pointer left its window");

	a_ptr_pair: assert property (
		state_reg == S_WBC && ram.valid |-> ram.we && ram.addr
		== (cfg1_reg[CFG1_AREA_B] ? CPTR_B_ADDR : CPTR_A_ADDR))
		else $error("pointer written back to wrong area");

	a_rtrt_flag: assert property (
		state_reg == S_COL && take && cnt_reg == 16'h0000 && !tx2_reg
		&& !cmd_reg[CMD_TR] && pw_reg.cmd_sync && !pw_reg.gap |=> rtrt_reg)
		else $error("terminal transfer flag not set");

	c_stored: cover property (state_reg == S_WBD && ram_fire);
	c_dropped: cover property (state_reg == S_LUT && ram_fire && !sel_bit);
	c_tx_only: cover property (state_reg == S_DP && ram_fire && first_reg);
	c_rollover: cover property (state_reg == S_WD && ram_fire
		&& ((dptr_reg + 16'h0001) & dmask) == 16'h0000);

endmodule

// ### rtl/smm_pkg.sv
// Shared constants and carrier types of the selective message monitor
package smm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Fixed shared-RAM locations
	localparam logic [15:0] LUT_BASE    = 16'h0280;
	localparam logic [15:0] CPTR_A_ADDR = 16'h0102;
	localparam logic [15:0] DPTR_A_ADDR = 16'h0103;
	localparam logic [15:0] CPTR_B_ADDR = 16'h0106;
	localparam logic [15:0] DPTR_B_ADDR = 16'h0107;

	////////////////////////////////////////////////////////////////////////
	// Configuration and start field positions
	localparam int CFG3_ENH     = 15;
	localparam int CFG3_CSZ_LO  = 11;
	localparam int CFG3_DSZ_LO  = 8;
	localparam int CFG1_ROLE    = 15;
	localparam int CFG1_MON     = 14;
	localparam int CFG1_AREA_B  = 13;
	localparam int CFG1_MSGMON  = 12;
	localparam int START_MON    = 1;

	// Command word fields
	localparam int CMD_TR       = 10;
	localparam int CMD_SA4      = 9;

	// Block status word bits
	localparam int BSW_EOM      = 15;
	localparam int BSW_CHB      = 13;
	localparam int BSW_ERR      = 12;
	localparam int BSW_RTRT     = 11;
	localparam int BSW_FMT      = 10;
	localparam int BSW_GOOD     = 8;
	localparam int BSW_ROLL     = 7;

	// Stack sizes at size code zero, entry length
	localparam int CMD_BASE_WORDS  = 256;
	localparam int DATA_BASE_WORDS = 512;
	localparam logic [1:0] ENTRY_LAST = 2'd3;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets and reset values
	localparam logic [7:0]  REG_CFG1  = 8'h00;
	localparam logic [7:0]  REG_CFG3  = 8'h04;
	localparam logic [7:0]  REG_START = 8'h08;
	localparam logic [7:0]  REG_STAT  = 8'h0C;
	localparam logic [15:0] CFG_RST   = 16'h0000;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [15:0] data;
		logic        cmd_sync;
		logic        chan_b;
		logic        gap;
		logic        ok;
	} smm_word_t;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} smm_ram_req_t;

endpackage

// ### rtl/smm_axil.sv
// AXI4-Lite register slave of the selective message monitor
`timescale 1ns/1ns
module smm_axil #(
	parameter int AXI_AW = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Register contents
	output logic [15:0]            cfg1_reg,
	output logic [15:0]            cfg3_reg,
	output logic                   start_reg,
	input  wire logic [31:0]       stat_word
);
	import smm_pkg::*;

	if (AXI_AW < 4) begin : g_chk
		$error("smm_axil needs at least 4 address bits");
	end

	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [7:0]        waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic [7:0]        ra;

	assign awready = ~aw_hold_reg & ~bvalid;
	assign wready  = ~w_hold_reg & ~bvalid;
	assign arready = ~rvalid;
	assign ra      = 8'(araddr);

	////////////////////////////////////////////////////////////////////////
	// Write path: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			waddr_reg   <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			bvalid      <= 1'b0;
			bresp       <= RESP_OKAY;
			cfg1_reg    <= CFG_RST;
			cfg3_reg    <= CFG_RST;
			start_reg   <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (awvalid && awready) begin
				aw_hold_reg <= 1'b1;
				waddr_reg   <= 8'(awaddr);
			end
			if (wvalid && wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= wdata;
				wstrb_reg  <= wstrb;
			end
			if (aw_hold_reg && w_hold_reg) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid      <= 1'b1;
				bresp       <= RESP_OKAY;
				unique case (waddr_reg)
					REG_CFG1: begin
						if (wstrb_reg[0]) cfg1_reg[7:0] <= wdata_reg[7:0];
						if (wstrb_reg[1]) cfg1_reg[15:8] <= wdata_reg[15:8];
					end
					REG_CFG3: begin
						if (wstrb_reg[0]) cfg3_reg[7:0] <= wdata_reg[7:0];
						if (wstrb_reg[1]) cfg3_reg[15:8] <= wdata_reg[15:8];
					end
					REG_START: start_reg <= wstrb_reg[0] & wdata_reg[START_MON];
					REG_STAT:  ;
					default:   bresp <= RESP_SLVERR;
				endcase
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			unique case (ra)
				REG_CFG1:  rdata <= {16'h0000, cfg1_reg};
				REG_CFG3:  rdata <= {16'h0000, cfg3_reg};
				REG_START: rdata <= '0;
				REG_STAT:  rdata <= stat_word;
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule

// ### bench/smm_ram_model.sv
// Shared RAM model answering the monitor's request port
`timescale 1ns/1ns
module smm_ram_model (
	// Clock
	input  wire logic                  aclk,
	// Request port
	input  wire smm_pkg::smm_ram_req_t ram,
	output logic                       ram_ack,
	output logic [15:0]                ram_rdata
);
	import smm_pkg::*;
	logic [15:0] mem [0:65535] = '{default: 16'h0000};
	initial ram_ack = 1'b0;
	// Ack every other cycle so the engine must really wait
	// Plain always: the bench also preloads mem by hierarchical writes
	always @(posedge aclk) begin
		ram_ack <= ram.valid && !ram_ack;
		if (ram.valid && ram_ack && ram.we) begin
			mem[ram.addr] <= ram.wdata;
		end
	end
	// Read data is garbage outside the acked cycle
	assign ram_rdata = ram_ack ? mem[ram.addr] : ~mem[ram.addr];
endmodule

// ### bench/smm_monitor_tb.sv
// Self-checking bench of the selective message monitor
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module smm_monitor_tb;
	import smm_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        wd_stb, msg_end, rt_active, chb;
	logic        awready, wready, bvalid, arready, rvalid, ram_ack, running;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp, rs, bs;
	logic [15:0] ram_rdata;
	smm_word_t    wd;
	smm_ram_req_t ram;
	int           fails = 0;
	int           checks_done = 0;

	smm_monitor u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .wd_stb, .wd, .msg_end, .rt_active, .ram, .ram_ack,
		.ram_rdata, .running);
	smm_ram_model u_ram (.aclk, .ram, .ram_ack, .ram_rdata);

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic hang(input logic late);
		if (late) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 60);
		bready <= 1'b0;
		bs = bresp;
		hang(!bvalid);
	endtask
	task automatic axr(input logic [7:0] a);
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 60);
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
		hang(!rvalid);
	endtask
	// Bus words arrive about 20 us apart
	task automatic word(input logic [15:0] d, input logic s, input logic g);
		@(posedge aclk);
		wd <= {d, s, chb, g, 1'b1};
		wd_stb <= 1'b1;
		@(posedge aclk);
		wd_stb <= 1'b0;
		repeat (200) @(posedge aclk);
	endtask
	task automatic msg(input logic [15:0] cmd, input logic [15:0] dat);
		word(cmd, 1'b1, 1'b1);
		word(dat, 1'b0, 1'b0);
		word(16'h2800, 1'b1, 1'b1);
		fin();
	endtask
	task automatic fin;
		@(posedge aclk);
		msg_end <= 1'b1;
		@(posedge aclk);
		msg_end <= 1'b0;
		repeat (200) @(posedge aclk);
	endtask
	// Terminal-to-terminal transfer after receive command rx
	task automatic rtrt(input logic [15:0] rx);
		word(rx, 1'b1, 1'b1);
		word(16'h3461, 1'b1, 1'b0);
		word(16'h3000, 1'b1, 1'b1);
		word(16'hBEEF, 1'b0, 1'b0);
		word(16'h2800, 1'b1, 1'b1);
		fin();
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_enable;
		axr(REG_CFG1);
		`CHK("cfg1 reset", {16'h0000, CFG_RST}, rd)
		axr(8'h10);
		`CHK("unmapped", RESP_SLVERR, rs)
		axw(8'h10, 32'h0000_FFFF);
		`CHK("unmapped write", RESP_SLVERR, bs)
		axw(REG_CFG3, 32'h0000_8000);
		axw(REG_CFG1, 32'h0000_5000);
		`CHK("cfg1 write", RESP_OKAY, bs)
		axr(REG_STAT);
		`CHK("idle before start", 1'b0, rd[0])
		rt_active <= 1'b1;
		axr(REG_STAT);
		`CHK("combined runs", 1'b1, rd[0])
		rt_active <= 1'b0;
	endtask
	task automatic t_nostart;
		u_ram.mem[16'h0294] = 16'h0008;
		u_ram.mem[16'h0102] = 16'h0400;
		u_ram.mem[16'h0103] = 16'h0800;
		msg(16'h2861, 16'h1234);
		`CHK("no store", 16'h0400, u_ram.mem[16'h0102])
	endtask
	task automatic t_receive;
		axw(REG_START, 32'h0000_0002);
		msg(16'h2861, 16'h1234);
		`CHK("eom", 1'b1, u_ram.mem[16'h0400][15])
		`CHK("chan a", 1'b0, u_ram.mem[16'h0400][13])
		`CHK("block start", 16'h0800, u_ram.mem[16'h0402])
		`CHK("command", 16'h2861, u_ram.mem[16'h0403])
		`CHK("data", 16'h1234, u_ram.mem[16'h0800])
		`CHK("status", 16'h2800, u_ram.mem[16'h0801])
		`CHK("cmd ptr", 16'h0404, u_ram.mem[16'h0102])
		`CHK("data ptr", 16'h0802, u_ram.mem[16'h0103])
		axr(REG_STAT);
		`CHK("last status", 32'h8100_0001, rd)
	endtask
	task automatic t_chan_b;
		chb <= 1'b1;
		// Odd word: all subaddresses but 19 enabled
		u_ram.mem[16'h0295] = 16'hFFF7;
		msg(16'h2A61, 16'h00C3);
		`CHK("dropped", 16'h0404, u_ram.mem[16'h0102])
		u_ram.mem[16'h0295] = 16'h0008;
		msg(16'h2A61, 16'h00C3);
		`CHK("command b", 16'h2A61, u_ram.mem[16'h0407])
		`CHK("chan b", 1'b1, u_ram.mem[16'h0404][13])
		`CHK("data b", 16'h00C3, u_ram.mem[16'h0802])
		`CHK("data ptr b", 16'h0804, u_ram.mem[16'h0103])
	endtask
	task automatic t_rtrt;
		rtrt(16'h2861);
		`CHK("rtrt flag", 1'b1, u_ram.mem[16'h0408][11])
		`CHK("rtrt first", 16'h3461, u_ram.mem[16'h0804])
		// Receive half disabled, transmit half enabled
		u_ram.mem[16'h029A] = 16'h0008;
		rtrt(16'h2881);
		`CHK("tx only flag", 1'b0, u_ram.mem[16'h040C][11])
		`CHK("tx only first", 16'h3461, u_ram.mem[16'h0808])
		`CHK("tx only last", 16'h2800, u_ram.mem[16'h080B])
		`CHK("tx only cmd", 16'h3461, u_ram.mem[16'h040F])
		// Disabled transmit command is dropped at lookup
		msg(16'h3481, 16'h5555);
		`CHK("tx dropped", 16'h0410, u_ram.mem[16'h0102])
	endtask
	task automatic t_area_b;
		u_ram.mem[16'h0106] = 16'h0500;
		u_ram.mem[16'h0107] = 16'h09FF;
		axw(REG_CFG1, 32'h0000_7000);
		msg(16'h2861, 16'hA5A5);
		`CHK("area a kept", 16'h0410, u_ram.mem[16'h0102])
		`CHK("cmd ptr area b", 16'h0504, u_ram.mem[16'h0106])
		`CHK("wrapped status", 16'h2800, u_ram.mem[16'h0800])
		`CHK("data ptr wrap", 16'h0801, u_ram.mem[16'h0107])
		`CHK("rollover", 1'b1, u_ram.mem[16'h0500][7])
	endtask
	task automatic t_combined;
		// Leaving monitor mode forgets the start command
		axw(REG_CFG1, 32'h0000_0000);
		axw(REG_CFG1, 32'h0000_7000);
		axr(REG_STAT);
		`CHK("start cleared", 1'b0, rd[0])
		rt_active <= 1'b1;
		msg(16'h2861, 16'h0F0F);
		rt_active <= 1'b0;
		`CHK("combined store", 16'h0508, u_ram.mem[16'h0106])
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{wd_stb, msg_end, rt_active, chb, awaddr, araddr, wdata, wd} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_enable();
		t_nostart();
		t_receive();
		t_chan_b();
		t_rtrt();
		t_area_b();
		t_combined();
		report_and_stop();
	end
endmodule
